//--- hdl/cli_ctrl.sv
// Channel latch, pair coupling, inrush restart, PWM and mode control with an AXI4-Lite slave.
// Overview of operation
// - Four pair bits couple channels 0-2,1-3,4-6,5-7.
// - Coupled pair: first fault also latches partner.
// - Coupling never switches a channel on.
// - Without inrush, latch holds until software clears.
// - Inrush bit set: latched channel restarts after delay.
// - Restart delay counter starts at channel switch-on.
// - Any commanded switch-off clears inrush bit, unless the inrush register is written in that cycle.
// - Inrush set: error flag sets, latch does not hold.
// - Timer clears inrush bit 40 ms after setting.
// - Inverse current keeps state; error only on overtemperature.
// - Inverse current disables overload and overtemperature protection.
// - Two independent PWM generators, each mapped to channels.
// - Both generators run from one trimmed base rate.
// - Active to limp-home within 100 us, status 868x.
// - Active to sleep within 100 us, status 0000.
// - New duty takes effect after current period ends.
// - Frequency code selects divide 1024/512/256 or 100%.
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module cli_ctrl
    import cli_pkg::*;
#(
    parameter int NCH = 8,
    parameter int MODE_CYC = MODE_DLY_CYC,
    parameter int BIM_LIMIT = BIM_CYC,
    parameter int RESTART_CYC = RESTART_CYC_DEF
)(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NCH-1:0] ovl_detect,
    input wire logic [NCH-1:0] otp_detect,
    input wire logic [NCH-1:0] inverse_current,
    input wire logic direct_input_zero,
    input wire logic direct_input_one,
    input wire logic mode_pin,
    output logic [NCH-1:0] channel_on,
    output logic [1:0] pwm_level,
    output logic irq
);
    // ****************************************************************
    // Reset release
    // ****************************************************************
    logic [1:0] rst_sync_q;
    logic rst_n;
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    // ****************************************************************
    // AXI4-Lite slave
    // ****************************************************************
    logic [ADDR_W-1:0] aw_q;
    logic aw_full_q;
    logic [31:0] w_q;
    logic w_full_q;
    logic wr_go;
    logic [NCH-1:0] out_q, inrush_q, latch_q, err_q, mask_q, cmd_q, cmd_prev_q;
    logic [3:0] pair_q, trim_q;
    logic [9:0] gen_q [2];
    logic [15:0] pwm_map_q, in_map_q, status_q;
    logic [31:0] rd_d;
    logic [1:0] rresp_d;
    assign s_axi_awready = !aw_full_q;
    assign s_axi_wready = !w_full_q;
    assign wr_go = aw_full_q && w_full_q && !s_axi_bvalid;
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_q <= '0;
            w_q <= 32'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_q <= s_axi_awaddr;
                aw_full_q <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_q <= s_axi_wdata;
                w_full_q <= 1'b1;
            end
            if (wr_go)
            begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_q > OFS_CH_STATE || aw_q[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    function automatic logic wr_hit(input logic [7:0] ofs);
        return wr_go && aw_q == ofs;
    endfunction

    always_comb
    begin
        rresp_d = RESP_OKAY;
        rd_d = 32'h0;
        if (s_axi_araddr == OFS_OUT_CTRL)
            rd_d[NCH-1:0] = out_q;
        else if (s_axi_araddr == OFS_PAIR)
            rd_d[3:0] = pair_q;
        else if (s_axi_araddr == OFS_INRUSH)
            rd_d[NCH-1:0] = inrush_q;
        else if (s_axi_araddr == OFS_LATCH_CLR)
            rd_d[NCH-1:0] = latch_q;
        else if (s_axi_araddr == OFS_TRIM)
            rd_d[3:0] = trim_q;
        else if (s_axi_araddr == OFS_GEN0)
            rd_d[9:0] = gen_q[0];
        else if (s_axi_araddr == OFS_GEN1)
            rd_d[9:0] = gen_q[1];
        else if (s_axi_araddr == OFS_PWM_MAP)
            rd_d[15:0] = pwm_map_q;
        else if (s_axi_araddr == OFS_IN_MAP)
            rd_d[15:0] = in_map_q;
        else if (s_axi_araddr == OFS_STATUS)
            rd_d[15:0] = status_q;
        else if (s_axi_araddr == OFS_IRQ_STAT)
            rd_d[NCH-1:0] = err_q;
        else if (s_axi_araddr == OFS_IRQ_MASK)
            rd_d[NCH-1:0] = mask_q;
        else if (s_axi_araddr == OFS_CH_STATE)
            rd_d[NCH-1:0] = channel_on;
        else
            rresp_d = RESP_SLVERR;
    end

    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_d;
            s_axi_rresp <= rresp_d;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_q <= '0;
            pair_q <= 4'h0;
            trim_q <= RST_TRIM;
            gen_q[0] <= 10'h0;
            gen_q[1] <= 10'h0;
            pwm_map_q <= 16'h0;
            in_map_q <= {IN_MAP_RST << 1, IN_MAP_RST};
            mask_q <= '0;
        end
        else
        begin
            if (wr_hit(OFS_OUT_CTRL))
                out_q <= w_q[NCH-1:0];
            if (wr_hit(OFS_PAIR))
                pair_q <= w_q[3:0];
            if (wr_hit(OFS_TRIM))
                trim_q <= w_q[3:0];
            if (wr_hit(OFS_GEN0))
                gen_q[0] <= w_q[9:0];
            if (wr_hit(OFS_GEN1))
                gen_q[1] <= w_q[9:0];
            if (wr_hit(OFS_PWM_MAP))
                pwm_map_q <= w_q[15:0];
            if (wr_hit(OFS_IN_MAP))
                in_map_q <= w_q[15:0];
            if (wr_hit(OFS_IRQ_MASK))
                mask_q <= w_q[NCH-1:0];
        end
    end

    // ****************************************************************
    // PWM generators
    // ****************************************************************
    logic [11:0] base_cnt_q;
    logic [11:0] base_div;
    logic base_tick;
    logic [9:0] pcnt_q [2];
    logic [9:0] sh_q [2];
    logic [1:0] wrap;
    always_comb
    begin
        if (trim_q == 4'h0)
            base_div = 12'(BASE_DIV_CYC);
        else
            base_div = 12'(BASE_DIV_CYC + (int'(TRIM_MID) - int'(trim_q)) * TRIM_STEP_CYC);
    end
    assign base_tick = base_cnt_q >= base_div - 12'h1;
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            base_cnt_q <= 12'h0;
        else if (base_tick)
            base_cnt_q <= 12'h0;
        else
            base_cnt_q <= base_cnt_q + 12'h1;
    end
    for (genvar g = 0; g < 2; g++)
    begin : gen_pwm
        assign wrap[g] = base_tick && pcnt_q[g] >= cli_last(sh_q[g][FREQ_LSB+:2]);
        always_ff @(posedge clk_sys or negedge rst_n)
        begin
            if (!rst_n)
            begin
                pcnt_q[g] <= 10'h0;
                sh_q[g] <= 10'h0;
                pwm_level[g] <= 1'b0;
            end
            else
            begin
                if (wrap[g])
                begin
                    pcnt_q[g] <= 10'h0;
                    sh_q[g] <= gen_q[g];
                end
                else if (base_tick)
                    pcnt_q[g] <= pcnt_q[g] + 10'h1;
                pwm_level[g] <= cli_level(pcnt_q[g], sh_q[g][DUTY_LSB+:8],
                                          sh_q[g][FREQ_LSB+:2]);
            end
        end
    end

    // ****************************************************************
    // Mode control
    // ****************************************************************
    cli_mode_t mode_q;
    logic [13:0] mode_cnt_q;
    logic any_in;
    assign any_in = direct_input_zero || direct_input_one;
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_q <= MD_ACTIVE;
            mode_cnt_q <= 14'h0;
        end
        else if (mode_pin)
        begin
            mode_q <= MD_ACTIVE;
            mode_cnt_q <= 14'h0;
        end
        else
        begin
            case (mode_q)
                MD_ACTIVE:
                    mode_q <= any_in ? MD_TO_LIMP : MD_TO_SLEEP;
                MD_TO_LIMP, MD_TO_SLEEP:
                begin
                    mode_cnt_q <= mode_cnt_q + 14'h1;
                    if (mode_cnt_q >= 14'(MODE_CYC - 2))
                    begin
                        mode_cnt_q <= 14'h0;
                        mode_q <= (mode_q == MD_TO_LIMP) ? MD_LIMP : MD_SLEEP;
                    end
                end
                MD_LIMP:
                    if (!any_in)
                        mode_q <= MD_SLEEP;
                MD_SLEEP:
                    if (any_in)
                        mode_q <= MD_LIMP;
                default:
                    mode_q <= MD_ACTIVE;
            endcase
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            status_q <= STAT_SLEEP;
        else if (mode_q == MD_LIMP)
            status_q <= STAT_LIMP_BASE | {14'h0, direct_input_one, direct_input_zero};
        else if (mode_q == MD_SLEEP)
            status_q <= STAT_SLEEP;
        else
            status_q <= {8'h00, latch_q};
    end

    // ****************************************************************
    // Channel command, latch, inrush restart
    // ****************************************************************
    logic [NCH-1:0] cmd_d, trip, latch_set, restart, cmd_fall, bim_done, err_evt;
    logic [15:0] rs_cnt_q [NCH];
    logic [22:0] bim_cnt_q [NCH];
    always_comb
    begin
        cmd_d = '0;
        if (mode_q == MD_LIMP)
            cmd_d = ({NCH{direct_input_zero}} & in_map_q[7:0])
                  | ({NCH{direct_input_one}} & in_map_q[15:8]);
        else if (mode_q != MD_SLEEP)
            cmd_d = out_q | ({NCH{pwm_level[0]}} & pwm_map_q[7:0])
                  | ({NCH{pwm_level[1]}} & pwm_map_q[MAP1_LSB+:8])
                  | ({NCH{direct_input_zero}} & in_map_q[7:0])
                  | ({NCH{direct_input_one}} & in_map_q[15:8]);
    end
    assign trip = channel_on & (ovl_detect | otp_detect) & ~inverse_current;
    assign err_evt = channel_on & (otp_detect | (ovl_detect & ~inverse_current));
    assign cmd_fall = cmd_prev_q & ~cmd_q;
    for (genvar i = 0; i < NCH; i++)
    begin : gen_ch
        assign latch_set[i] = trip[i] || (pair_q[cli_pair_idx(i)] && trip[i ^ 2]);
        assign restart[i] = inrush_q[i] && latch_q[i]
                          && rs_cnt_q[i] >= 16'(RESTART_CYC - 1);
        assign bim_done[i] = inrush_q[i] && bim_cnt_q[i] >= 23'(BIM_LIMIT - 1);
        always_ff @(posedge clk_sys or negedge rst_n)
        begin
            if (!rst_n)
                rs_cnt_q[i] <= 16'h0;
            else if ((cmd_q[i] && !cmd_prev_q[i]) || restart[i])
                rs_cnt_q[i] <= 16'h0;
            else if (cmd_q[i] && rs_cnt_q[i] < 16'(RESTART_CYC - 1))
                rs_cnt_q[i] <= rs_cnt_q[i] + 16'h1;
        end
        always_ff @(posedge clk_sys or negedge rst_n)
        begin
            if (!rst_n)
                bim_cnt_q[i] <= 23'h0;
            else if (!inrush_q[i] || wr_hit(OFS_INRUSH))
                bim_cnt_q[i] <= 23'h0;
            else
                bim_cnt_q[i] <= bim_cnt_q[i] + 23'h1;
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmd_q <= '0;
            cmd_prev_q <= '0;
            latch_q <= '0;
            inrush_q <= '0;
            err_q <= '0;
            channel_on <= '0;
        end
        else
        begin
            cmd_q <= cmd_d;
            cmd_prev_q <= cmd_q;
            latch_q <= latch_set | (latch_q & ~restart
                       & ~(wr_hit(OFS_LATCH_CLR) ? w_q[NCH-1:0] : '0));
            if (wr_hit(OFS_INRUSH))
                inrush_q <= w_q[NCH-1:0];
            else
                inrush_q <= inrush_q & ~cmd_fall & ~bim_done;
            err_q <= err_evt | (err_q & ~(wr_hit(OFS_IRQ_STAT) ? w_q[NCH-1:0] : '0));
            channel_on <= cmd_q & ~latch_q & ~latch_set;
        end
    end
    assign irq = |(err_q & mask_q);

    // ****************************************************************
    // Checks
    // ****************************************************************
    AST_PAIR_COUPLE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (pair_q[0] && trip[0]) |=> latch_q[2] && !channel_on[2])
        else $error("Coupled partner not latched.");
    AST_PAIR_MAP: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!pair_q[0] && trip[0] && !trip[2]) |=> !latch_q[2] || $past(latch_q[2]))
        else $error("Uncoupled channel latched by neighbour.");
    AST_NO_PARTNER_ON: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(channel_on[2]) |-> $past(cmd_q[2]))
        else $error("Channel on without its own command.");
    AST_LATCH_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (latch_q[0] && !inrush_q[0] && !wr_hit(OFS_LATCH_CLR)) |=> latch_q[0])
        else $error("Latch released without clear.");
    AST_RESTART: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (restart[1] && !latch_set[1]) |=> !latch_q[1] ##0 rs_cnt_q[1] == 16'h0)
        else $error("Inrush restart did not release latch.");
    AST_CNT_START: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cmd_q[0] && !cmd_prev_q[0]) |=> rs_cnt_q[0] == 16'h0)
        else $error("Restart counter not started at switch on.");
    AST_OFF_CLR: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cmd_fall[3] && !wr_hit(OFS_INRUSH)) |=> !inrush_q[3])
        else $error("Switch off left inrush bit set.");
    AST_BIM_EXPIRE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (bim_done[1] && !wr_hit(OFS_INRUSH)) |=> !inrush_q[1])
        else $error("Inrush timer did not clear bit.");
    AST_INV_NOPROT: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (inverse_current[0] && !latch_q[0] && !(pair_q[0] && trip[2])) |=> !latch_q[0])
        else $error("Protection acted under inverse current.");
    AST_FULL_ON: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (sh_q[0][FREQ_LSB+:2] == FREQ_FULL) [*2] |-> pwm_level[0])
        else $error("Code 11 not constant high.");
    AST_DUTY_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !wrap[0] |=> $stable(sh_q[0]))
        else $error("Duty changed inside a period.");
    AST_LIMP_WORD: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (mode_q == MD_LIMP && $past(mode_q) == MD_LIMP) |-> status_q[15:2] == STAT_LIMP_BASE[15:2])
        else $error("Limp-home status word wrong.");
    AST_SLEEP_WORD: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(mode_q == MD_SLEEP) |=> status_q == STAT_SLEEP)
        else $error("Sleep status word not zero.");
endmodule
`default_nettype wire

//--- hdl/cli_pkg.sv
// Constants, register map and helper functions for the channel latch and inrush control block.
package cli_pkg;
    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int CLK_MHZ = 125;
    localparam int MODE_DLY_US = 100;
    localparam int MODE_DLY_CYC = MODE_DLY_US * CLK_MHZ;
    localparam int BIM_MS = 40;
    localparam int BIM_CYC = BIM_MS * 1000 * CLK_MHZ;
    localparam int RESTART_CYC_DEF = 1024;
    localparam int F_INT_HZ = 102400;
    localparam int BASE_DIV_CYC = (CLK_MHZ * 1000000) / F_INT_HZ;
    localparam int TRIM_STEP_CYC = 64;
    localparam logic [3:0] TRIM_MID = 4'h8;
    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_OUT_CTRL = 8'h00;
    localparam logic [7:0] OFS_PAIR = 8'h04;
    localparam logic [7:0] OFS_INRUSH = 8'h08;
    localparam logic [7:0] OFS_LATCH_CLR = 8'h0c;
    localparam logic [7:0] OFS_TRIM = 8'h10;
    localparam logic [7:0] OFS_GEN0 = 8'h14;
    localparam logic [7:0] OFS_GEN1 = 8'h18;
    localparam logic [7:0] OFS_PWM_MAP = 8'h1c;
    localparam logic [7:0] OFS_IN_MAP = 8'h20;
    localparam logic [7:0] OFS_STATUS = 8'h24;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h28;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h2c;
    localparam logic [7:0] OFS_CH_STATE = 8'h30;
    localparam int DUTY_LSB = 0;
    localparam int FREQ_LSB = 8;
    localparam int MAP1_LSB = 8;
    localparam logic [1:0] FREQ_FULL = 2'h3;
    localparam logic [1:0] FREQ_DIV512 = 2'h1;
    localparam logic [1:0] FREQ_DIV256 = 2'h2;
    localparam logic [9:0] LAST_1024 = 10'h3ff;
    localparam logic [9:0] LAST_512 = 10'h1ff;
    localparam logic [9:0] LAST_256 = 10'h0ff;
    localparam logic [15:0] STAT_LIMP_BASE = 16'h8680;
    localparam logic [15:0] STAT_SLEEP = 16'h0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [7:0] IN_MAP_RST = 8'h01;
    localparam logic [3:0] RST_TRIM = 4'h8;

    typedef enum logic [4:0] {
        MD_ACTIVE = 5'h01,
        MD_TO_LIMP = 5'h02,
        MD_LIMP = 5'h04,
        MD_TO_SLEEP = 5'h08,
        MD_SLEEP = 5'h10
    } cli_mode_t;

    // Pair-enable bit that governs a channel: channel bits 2 and 0 select it.
    function automatic logic [1:0] cli_pair_idx(input int ch);
        logic [2:0] c;
        c = ch[2:0];
        return {c[2], c[0]};
    endfunction

    // Last count of a generator period for a frequency code.
    function automatic logic [9:0] cli_last(input logic [1:0] f);
        if (f == FREQ_DIV512)
            return LAST_512;
        else if (f == FREQ_DIV256)
            return LAST_256;
        return LAST_1024;
    endfunction

    // Output level of a generator for its period count, duty and frequency code.
    function automatic logic cli_level(input logic [9:0] c, input logic [7:0] d,
                                       input logic [1:0] f);
        logic [7:0] s;
        s = c[9:2];
        if (f == FREQ_FULL)
            return 1'b1;
        if (f == FREQ_DIV512)
            s = c[8:1];
        else if (f == FREQ_DIV256)
            s = c[7:0];
        return s < d;
    endfunction
endpackage

//--- tb/cli_load_model.sv
// Load-side fault detector model for the channel latch and inrush control block.
`timescale 1ns/1ps
`default_nettype none
module cli_load_model (
    input wire logic [7:0] channel_on,
    input wire logic [7:0] ovl_arm,
    input wire logic [7:0] otp_arm,
    output logic [7:0] ovl_detect,
    output logic [7:0] otp_detect
);
    // Faults show only while a channel conducts, as a real detector does.
    assign ovl_detect = channel_on & ovl_arm;
    assign otp_detect = channel_on & otp_arm;
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Self-checking testbench for the channel latch and inrush control block.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import cli_pkg::*;
;
    logic clk_sys, resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic direct_input_zero, direct_input_one, mode_pin;
    logic [7:0] s_axi_awaddr, s_axi_araddr, ovl_detect, otp_detect, inverse_current, channel_on;
    logic [7:0] ovl_arm, otp_arm;
    logic [31:0] s_axi_wdata, s_axi_rdata, q;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, pwm_level, r;
    int error_cnt = 0;
    int num_checks = 0;
    int cycles = 0;
    int a;
    cli_ctrl #(.MODE_CYC(20), .BIM_LIMIT(200), .RESTART_CYC(16)) cli_ctrl_i (.clk_sys, .resetn,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ovl_detect,
        .otp_detect, .inverse_current, .direct_input_zero, .direct_input_one, .mode_pin,
        .channel_on, .pwm_level, .irq);
    cli_load_model cli_load_model_i (.channel_on, .ovl_arm, .otp_arm, .ovl_detect, .otp_detect);
    // ****************************************************************
    // Clock, timeout and bus tasks
    // ****************************************************************
    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            error_cnt++;
            close_out();
        end
    end
    task close_out();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // Ready and answer are sampled at the falling edge and acted on at the next rising edge.
    task xfer(input logic rd, input logic [7:0] ad, input logic [31:0] d);
        logic ta, tw, tr;
        int n;
        n = 0;
        tr = 1'b0;
        @(posedge clk_sys);
        if (rd)
        begin
            s_axi_araddr <= ad;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
        end
        else
        begin
            s_axi_awaddr <= ad;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
        end
        while (!tr && n < 100)
        begin
            @(negedge clk_sys);
            ta = rd ? (s_axi_arvalid && s_axi_arready) : (s_axi_awvalid && s_axi_awready);
            tw = s_axi_wvalid && s_axi_wready;
            tr = rd ? s_axi_rvalid : s_axi_bvalid;
            q = s_axi_rdata;
            r = rd ? s_axi_rresp : s_axi_bresp;
            @(posedge clk_sys);
            if (ta)
            begin
                s_axi_arvalid <= 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (tw)
                s_axi_wvalid <= 1'b0;
            if (tr)
            begin
                s_axi_rready <= 1'b0;
                s_axi_bready <= 1'b0;
            end
            n++;
        end
        if (!tr)
            chk(32'h1, 32'h0);
    endtask
    task wr(input logic [7:0] ad, input logic [31:0] d);
        xfer(1'b0, ad, d);
    endtask
    task rd(input logic [7:0] ad, input logic [31:0] e);
        xfer(1'b1, ad, 32'h0);
        chk(q, e);
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial
    begin
        {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, ovl_arm, otp_arm, inverse_current} = 72'h0;
        {direct_input_zero, direct_input_one, mode_pin, s_axi_wstrb} = 7'h1f;
        cyc(5);
        resetn <= 1'b1;
        cyc(3);
        rd(OFS_TRIM, {28'h0, RST_TRIM});
        @(negedge clk_sys) chk(pwm_level, 32'h0);
        xfer(1'b1, 8'hfc, 32'h0);
        chk(r, RESP_SLVERR);
        xfer(1'b0, 8'h03, 32'h1);
        chk(r, RESP_SLVERR);
        wr(OFS_OUT_CTRL, 32'h05);
        ovl_arm <= 8'h01;
        cyc(3);
        ovl_arm <= 8'h00;
        cyc(20);
        @(negedge clk_sys) chk(channel_on, 32'h04);
        rd(OFS_LATCH_CLR, 32'h01);
        rd(OFS_IRQ_STAT, 32'h01);
        @(negedge clk_sys) chk(irq, 32'h0);
        wr(OFS_IRQ_MASK, 32'h01);
        @(negedge clk_sys) chk(irq, 32'h1);
        wr(OFS_IRQ_STAT, 32'h01);
        @(negedge clk_sys) chk(irq, 32'h0);
        wr(OFS_LATCH_CLR, 32'h01);
        cyc(3);
        @(negedge clk_sys) chk(channel_on, 32'h05);
        for (int p = 0; p < 4; p++)
        begin
            a = {p[1], 1'b0, p[0]};
            wr(OFS_PAIR, 32'h1 << p);
            wr(OFS_OUT_CTRL, 32'h5 << a);
            otp_arm <= 8'h01 << a;
            cyc(3);
            otp_arm <= 8'h00;
            @(negedge clk_sys) chk(channel_on, 32'h0);
            wr(OFS_LATCH_CLR, 32'hff);
            wr(OFS_OUT_CTRL, 32'h4 << a);
            cyc(3);
            @(negedge clk_sys) chk(channel_on, 32'h4 << a);
        end
        wr(OFS_IRQ_STAT, 32'hff);
        wr(OFS_OUT_CTRL, 32'h01);
        inverse_current <= 8'h01;
        ovl_arm <= 8'h01;
        cyc(4);
        @(negedge clk_sys) chk(channel_on, 32'h01);
        rd(OFS_IRQ_STAT, 32'h0);
        otp_arm <= 8'h01;
        cyc(2);
        @(negedge clk_sys) chk(channel_on, 32'h01);
        rd(OFS_IRQ_STAT, 32'h01);
        inverse_current <= 8'h00;
        ovl_arm <= 8'h00;
        otp_arm <= 8'h00;
        wr(OFS_INRUSH, 32'h02);
        wr(OFS_OUT_CTRL, 32'h03);
        ovl_arm <= 8'h02;
        cyc(3);
        ovl_arm <= 8'h00;
        cyc(1);
        @(negedge clk_sys) chk(channel_on, 32'h01);
        cyc(24);
        @(negedge clk_sys) chk(channel_on, 32'h03);
        rd(OFS_IRQ_STAT, 32'h03);
        cyc(200);
        rd(OFS_INRUSH, 32'h0);
        wr(OFS_INRUSH, 32'h08);
        wr(OFS_OUT_CTRL, 32'h0b);
        wr(OFS_OUT_CTRL, 32'h03);
        cyc(3);
        rd(OFS_INRUSH, 32'h0);
        direct_input_zero <= 1'b1;
        mode_pin <= 1'b0;
        cyc(30);
        rd(OFS_STATUS, 32'h8681);
        direct_input_one <= 1'b1;
        cyc(2);
        rd(OFS_STATUS, 32'h8683);
        {mode_pin, direct_input_zero, direct_input_one} <= 3'b100;
        cyc(5);
        mode_pin <= 1'b0;
        cyc(30);
        rd(OFS_STATUS, 32'h0);
        close_out();
    end
endmodule
`default_nettype wire
